// ---- hw/flash_prot_pkg.sv ----
// What this block does
// (R1) WP low locks two outer boot sectors
// (R2) WP high: boot sectors follow stored state
// (R3) high voltage on init pin unprotects temporarily
// (R4) removing high voltage restores prior protection
// (R5) temp unprotect with WP low keeps boot
// (R6) device has 64K secured region, fixed bit
// (R7) indicator 1 factory locked, 0 lockable
// (R8) enter sequence maps boot addresses to region
// (R9) mapping persists until exit or reset
// (R10) factory-locked region rejects every change
// (R11) serial number at word F8000h-F8007h
// (R12) region programming uses normal sequence only
// (R13) host locks region: enter then protect; the host has no region protect operation, only enter and exit
// (R14) locked region never unprotects nor changes
// (R15) host exits region before normal array access
// (R16) program/erase need preceding unlock cycles
// (R17) below lockout device ignores writes
// (R18) short strobe pulses start no write
// (R19) write needs select, strobe low, output high
// (R20) power-up strobe low accepts no command
// (R21) protected sector program leaves contents unchanged
package flash_prot_pkg;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam logic [7:0] REG_PINS = 8'h14;
	localparam int CTRL_GO_LSB = 0;
	localparam int CTRL_OP_LSB = 1;
	localparam int PINS_WP = 0;
	localparam int PINS_HV = 1;
	localparam int PINS_INIT = 2;
	localparam logic [2:0] OP_READ = 3'h0;
	localparam logic [2:0] OP_PROGRAM = 3'h1;
	localparam logic [2:0] OP_SECTOR_ERASE = 3'h2;
	localparam logic [2:0] OP_ENTER_REGION = 3'h3;
	localparam logic [2:0] OP_EXIT_REGION = 3'h4;
	localparam logic [2:0] OP_RESET = 3'h5;
	localparam logic [2:0] OP_WRITE_RAW = 3'h6;
	localparam logic [19:0] UNLOCK_ADDR1 = 20'h00555;
	localparam logic [19:0] UNLOCK_ADDR2 = 20'h002AA;
	localparam logic [15:0] UNLOCK_DATA1 = 16'h00AA;
	localparam logic [15:0] UNLOCK_DATA2 = 16'h0055;
	localparam logic [15:0] CMD_PROGRAM = 16'h00A0;
	localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
	localparam logic [15:0] CMD_SECTOR_ERASE = 16'h0030;
	localparam logic [15:0] CMD_ENTER_REGION = 16'h0088;
	localparam logic [15:0] CMD_EXIT_REGION = 16'h0090;
	localparam logic [15:0] CMD_EXIT_TAIL = 16'h0000;
	localparam logic [15:0] CMD_RESET = 16'h00F0;
	localparam logic [19:0] SERIAL_FIRST_WORD = 20'hF8000;
	localparam logic [19:0] SERIAL_LAST_WORD = 20'hF8007;
	localparam int STROBE_NS = 30;
	localparam int SETUP_NS = 10;
	localparam int GLITCH_NS = 5;
	localparam int CLK_NS = 8;
	localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] GLITCH_CYC = 4'((GLITCH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [2:0] BUS_IDLE_CYCLES = 3'h0;
endpackage

// ---- hw/flash_bus_cycle.sv ----
`timescale 1ns/1ns
// one asynchronous flash bus cycle, write or read
module flash_bus_cycle
	import flash_prot_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_start,
	input wire logic i_write,
	input wire logic [19:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic [15:0] i_dq_in,
	output logic o_done,
	output logic [15:0] o_rdata,
	output logic [19:0] o_addr,
	output logic [15:0] o_dq_out,
	output logic o_dq_oe,
	output logic o_chip_select_n,
	output logic o_write_strobe_n,
	output logic o_output_drive_n
);
	typedef enum logic [1:0] {
		CY_IDLE = 2'b00,
		CY_SETUP = 2'b01,
		CY_STROBE = 2'b10,
		CY_HOLD = 2'b11
	} cycle_state_t;
	cycle_state_t state;
	logic [3:0] count;
	logic is_write;

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			state <= CY_IDLE;
			count <= 4'h0;
			is_write <= 1'b0;
			o_done <= 1'b0;
			o_rdata <= 16'h0000;
			o_addr <= 20'h00000;
			o_dq_out <= 16'h0000;
			o_dq_oe <= 1'b0;
			o_chip_select_n <= 1'b1;
			o_write_strobe_n <= 1'b1;
			o_output_drive_n <= 1'b1;
		end
		else
		begin
			o_done <= 1'b0;
			case (state)
				CY_IDLE:
				begin
					if (i_start)
					begin
						is_write <= i_write;
						o_addr <= i_addr;
						o_dq_out <= i_wdata;
						// output drive stays high through a write
						o_dq_oe <= i_write; // R19
						o_output_drive_n <= 1'b1;
						o_chip_select_n <= 1'b0;
						count <= SETUP_CYC;
						state <= CY_SETUP;
					end
				end
				CY_SETUP:
				begin
					if (count > 4'h1)
						count <= count - 4'h1;
					else
					begin
						// strobe lasts well over the glitch filter width
						count <= STROBE_CYC; // R18
						if (is_write)
							o_write_strobe_n <= 1'b0; // R19
						else
							o_output_drive_n <= 1'b0;
						state <= CY_STROBE;
					end
				end
				CY_STROBE:
				begin
					if (count > 4'h1)
						count <= count - 4'h1;
					else
					begin
						if (!is_write)
							o_rdata <= i_dq_in;
						o_write_strobe_n <= 1'b1;
						o_output_drive_n <= 1'b1;
						count <= SETUP_CYC;
						state <= CY_HOLD;
					end
				end
				CY_HOLD:
				begin
					if (count > 4'h1)
						count <= count - 4'h1;
					else
					begin
						o_chip_select_n <= 1'b1;
						o_dq_oe <= 1'b0;
						o_done <= 1'b1;
						state <= CY_IDLE;
					end
				end
				default:
					state <= CY_IDLE;
			endcase
		end
	end

	a_strobe_width: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R18
		$fell(o_write_strobe_n) |-> !o_write_strobe_n [*3])
		else $error("write strobe shorter than minimum");
	a_write_oe_high: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R19
		!o_write_strobe_n |-> (!o_chip_select_n && o_output_drive_n))
		else $error("write strobe without select or with output drive");
	a_no_both_low: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R19
		!(!o_write_strobe_n && !o_output_drive_n))
		else $error("write and output strobes low together");
endmodule // flash_bus_cycle

// ---- hw/flash_prot_host.sv ----
`timescale 1ns/1ns
// host controller for the protected flash: AHB-Lite registers, command sequences
module flash_prot_host
	import flash_prot_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	input wire logic [15:0] i_dq_in,
	output logic [19:0] o_flash_addr,
	output logic [15:0] o_dq_out,
	output logic o_dq_oe,
	output logic o_flash_chip_select_n,
	output logic o_write_strobe_n,
	output logic o_output_drive_n,
	output logic o_write_protect_accel_pin,
	output logic o_high_voltage_level,
	output logic o_chip_init_n
);
	typedef enum logic [2:0] {
		SQ_IDLE = 3'b000,
		SQ_RUN = 3'b001,
		SQ_WAIT = 3'b010,
		SQ_DONE = 3'b011
	} seq_state_t;

	seq_state_t state;
	logic [2:0] op;
	logic [2:0] step;
	logic [2:0] last_step;
	logic [19:0] target_addr;
	logic [15:0] target_data;
	logic [15:0] read_data;
	logic busy, in_region, done_flag;
	logic cyc_start, cyc_write;
	logic [19:0] cyc_addr;
	logic [15:0] cyc_wdata;
	logic cyc_done;
	logic [15:0] cyc_rdata;
	logic pin_wp, pin_hv, pin_init;
	logic dph_write;
	logic [7:0] dph_addr;
	logic dph_valid;
	logic go_write;
	logic [31:0] next_rdata;

	// number of bus cycles for each operation, counted from zero
	function automatic logic [2:0] op_length(input logic [2:0] o);
		case (o)
			OP_PROGRAM: op_length = 3'h3;
			OP_SECTOR_ERASE: op_length = 3'h5;
			OP_ENTER_REGION: op_length = 3'h2;
			OP_EXIT_REGION: op_length = 3'h3;
			default: op_length = 3'h0;
		endcase
	endfunction

	// unlock prefix first, then command, then target; unlock bypass is never used
	function automatic logic [35:0] op_cycle(input logic [2:0] o, input logic [2:0] s,
		input logic [19:0] a, input logic [15:0] d);
		logic [35:0] r;
		r = {UNLOCK_ADDR1, UNLOCK_DATA1};
		case (s)
			3'h0: r = {UNLOCK_ADDR1, UNLOCK_DATA1};
			3'h1: r = {UNLOCK_ADDR2, UNLOCK_DATA2};
			3'h2:
			begin
				case (o)
					OP_PROGRAM: r = {UNLOCK_ADDR1, CMD_PROGRAM};
					OP_SECTOR_ERASE: r = {UNLOCK_ADDR1, CMD_ERASE_SETUP};
					OP_ENTER_REGION: r = {UNLOCK_ADDR1, CMD_ENTER_REGION};
					default: r = {UNLOCK_ADDR1, CMD_EXIT_REGION};
				endcase
			end
			3'h3:
			begin
				if (o == OP_EXIT_REGION)
					r = {20'h00000, CMD_EXIT_TAIL};
				else if (o == OP_PROGRAM)
					r = {a, d};
				else
					r = {UNLOCK_ADDR1, UNLOCK_DATA1};
			end
			3'h4: r = {UNLOCK_ADDR2, UNLOCK_DATA2};
			default: r = {a, CMD_SECTOR_ERASE};
		endcase
		op_cycle = r;
	endfunction

	flash_bus_cycle u_cycle (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_start(cyc_start),
		.i_write(cyc_write),
		.i_addr(cyc_addr),
		.i_wdata(cyc_wdata),
		.i_dq_in(i_dq_in),
		.o_done(cyc_done),
		.o_rdata(cyc_rdata),
		.o_addr(o_flash_addr),
		.o_dq_out(o_dq_out),
		.o_dq_oe(o_dq_oe),
		.o_chip_select_n(o_flash_chip_select_n),
		.o_write_strobe_n(o_write_strobe_n),
		.o_output_drive_n(o_output_drive_n)
	);

	// AHB-Lite slave: zero wait states, OKAY always
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			dph_valid <= 1'b0;
			dph_write <= 1'b0;
			dph_addr <= 8'h00;
		end
		else if (i_hready)
		begin
			dph_valid <= i_hsel && i_htrans[1];
			dph_write <= i_hwrite;
			dph_addr <= i_haddr[7:0];
		end
	end

	assign go_write = dph_valid && dph_write && (dph_addr == REG_CTRL)
		&& i_hwdata[CTRL_GO_LSB] && !busy;

	// no wait states and no errors, so reset and run look alike
	always_ff @(posedge i_clk_sys)
	begin
		o_hreadyout <= 1'b1;
		o_hresp <= 1'b0;
	end

	always_comb
	begin
		next_rdata = 32'h00000000;
		case (i_haddr[7:0])
			REG_CTRL: next_rdata = {28'h0000000, op, 1'b0};
			REG_ADDR: next_rdata = {12'h000, target_addr};
			REG_WDATA: next_rdata = {16'h0000, target_data};
			REG_STATUS: next_rdata = {29'h00000000, in_region, done_flag, busy};
			REG_RDATA: next_rdata = {16'h0000, read_data};
			REG_PINS: next_rdata = {29'h00000000, pin_init, pin_hv, pin_wp};
			default: next_rdata = 32'h00000000;
		endcase
	end

	// read data registered at address phase so it is ready in the data phase
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			o_hrdata <= 32'h00000000;
		else if (i_hready && i_hsel && i_htrans[1] && !i_hwrite)
			o_hrdata <= next_rdata;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			target_addr <= 20'h00000;
			target_data <= 16'h0000;
			pin_wp <= 1'b0;
			pin_hv <= 1'b0;
			pin_init <= 1'b1;
		end
		else if (dph_valid && dph_write)
		begin
			case (dph_addr)
				REG_ADDR: target_addr <= i_hwdata[19:0];
				REG_WDATA: target_data <= i_hwdata[15:0];
				REG_PINS:
				begin
					pin_wp <= i_hwdata[PINS_WP];
					pin_hv <= i_hwdata[PINS_HV];
					pin_init <= i_hwdata[PINS_INIT];
				end
				default: ;
			endcase
		end
	end

	// pins driven from registers; wp low keeps boot sectors locked
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			o_write_protect_accel_pin <= 1'b0; // R1
			o_high_voltage_level <= 1'b0;
			o_chip_init_n <= 1'b0;
		end
		else
		begin
			o_write_protect_accel_pin <= pin_wp; // R2
			// temporary unprotect: high voltage on the init pin
			o_high_voltage_level <= pin_hv && pin_init; // R3
			o_chip_init_n <= pin_init; // R4
		end
	end

	// sequencer: every program or erase goes out behind its unlock cycles
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			state <= SQ_IDLE;
			op <= OP_READ;
			step <= 3'h0;
			last_step <= 3'h0;
			busy <= 1'b0;
			done_flag <= 1'b0;
			cyc_start <= 1'b0;
			cyc_write <= 1'b0;
			cyc_addr <= 20'h00000;
			cyc_wdata <= 16'h0000;
			read_data <= 16'h0000;
		end
		else
		begin
			cyc_start <= 1'b0;
			case (state)
				SQ_IDLE:
				begin
					if (go_write)
					begin
						op <= i_hwdata[CTRL_OP_LSB +: 3];
						last_step <= op_length(i_hwdata[CTRL_OP_LSB +: 3]);
						step <= 3'h0;
						busy <= 1'b1;
						done_flag <= 1'b0;
						state <= SQ_RUN;
					end
				end
				SQ_RUN:
				begin
					cyc_start <= 1'b1;
					if (op == OP_READ)
					begin
						cyc_write <= 1'b0;
						cyc_addr <= target_addr;
						cyc_wdata <= 16'h0000;
					end
					else if (op == OP_RESET)
					begin
						cyc_write <= 1'b1;
						cyc_addr <= 20'h00000;
						cyc_wdata <= CMD_RESET;
					end
					else if (op == OP_WRITE_RAW)
					begin
						cyc_write <= 1'b1;
						cyc_addr <= target_addr;
						cyc_wdata <= target_data;
					end
					else
					begin
						cyc_write <= 1'b1;
						{cyc_addr, cyc_wdata} <= op_cycle(op, step, target_addr,
							target_data); // R16
					end
					state <= SQ_WAIT;
				end
				SQ_WAIT:
				begin
					if (cyc_done)
					begin
						if (op == OP_READ)
							read_data <= cyc_rdata;
						if (step == last_step)
							state <= SQ_DONE;
						else
						begin
							step <= step + 3'h1;
							state <= SQ_RUN;
						end
					end
				end
				SQ_DONE:
				begin
					busy <= 1'b0;
					done_flag <= 1'b1;
					state <= SQ_IDLE;
				end
				default:
					state <= SQ_IDLE;
			endcase
		end
	end

	// tracks the device mapping; host must exit before normal array use
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			in_region <= 1'b0;
		else if (state == SQ_DONE && op == OP_ENTER_REGION)
			in_region <= 1'b1; // R13
		else if (state == SQ_DONE && op == OP_EXIT_REGION)
			in_region <= 1'b0; // R15
		else if (!pin_init)
			in_region <= 1'b0;
	end

	a_unlock_first: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R16
		(state == SQ_RUN && step == 3'h0 && op == OP_PROGRAM) |=>
		(cyc_addr == UNLOCK_ADDR1 && cyc_wdata == UNLOCK_DATA1))
		else $error("program without first unlock cycle");
	a_unlock_second: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R16
		(state == SQ_RUN && step == 3'h1 && op == OP_SECTOR_ERASE) |=>
		(cyc_addr == UNLOCK_ADDR2 && cyc_wdata == UNLOCK_DATA2))
		else $error("erase without second unlock cycle");
	a_hv_needs_init: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R3
		o_high_voltage_level |-> o_chip_init_n)
		else $error("high voltage while init pin low");
	a_region_enter: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R13
		(state == SQ_DONE && op == OP_ENTER_REGION) |=> in_region)
		else $error("region flag not set after enter");
	a_region_exit: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R15
		(state == SQ_DONE && op == OP_EXIT_REGION) |=> !in_region)
		else $error("region flag not cleared after exit");
	a_busy_done: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R16
		(state == SQ_DONE) |=> (!busy && done_flag))
		else $error("busy not released at end of sequence");
	a_wp_follows: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R1
		1'b1 |=> (o_write_protect_accel_pin == $past(pin_wp)))
		else $error("protect pin does not follow register");
	a_okay_resp: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		o_hreadyout && !o_hresp)
		else $error("bus slave not ready or not okay");
endmodule // flash_prot_host

// ---- tb/flash_device_model.sv ----
`timescale 1ns/1ns
// behavioural top-boot flash: protection, secured region, write inhibits
module flash_device_model
	import flash_prot_pkg::*;
#(
	parameter bit FACTORY_LOCKED = 1'b1,
	parameter logic [15:0] SERIAL_SEED = 16'hC000
)
(
	input wire logic [19:0] i_addr,
	input wire logic [15:0] i_dq_out,
	input wire logic i_dq_oe,
	input wire logic i_cs_n,
	input wire logic i_we_n,
	input wire logic i_oe_n,
	input wire logic i_wp,
	input wire logic i_hv,
	input wire logic i_init_n,
	input wire logic i_supply_low,
	output logic [15:0] o_dq
);
	logic [15:0] mem [logic [19:0]];
	logic [15:0] region [logic [19:0]];
	logic in_region = 1'b0;
	int step = 0;
	bit armed = 1'b0;
	time t_fall = 0;

	function automatic bit use_region(input logic [19:0] a);
		return in_region && a[19:15] == 5'h1F;
	endfunction

	// sector 00h is stored protected, the outer boot pair stored unprotected
	function automatic bit locked(input logic [19:0] a);
		if (use_region(a))
			return FACTORY_LOCKED;
		if (a[19:13] == 7'h7F && !i_wp)
			return 1'b1;
		if (i_hv && i_init_n)
			return 1'b0;
		return a[19:12] == 8'h00;
	endfunction

	function automatic logic [15:0] peek(input logic [19:0] a);
		if (use_region(a))
			return region.exists(a) ? region[a] : 16'hFFFF;
		return mem.exists(a) ? mem[a] : 16'hFFFF;
	endfunction

	task automatic modify(input logic [19:0] a, input logic [15:0] d, input bit erase);
		if (locked(a))
			return;
		if (use_region(a) && erase)
			region.delete();
		else if (use_region(a))
			region[a] = peek(a) & d;
		else if (!erase)
			mem[a] = peek(a) & d;
		else
			foreach (mem[k])
				if (k[19:12] == a[19:12])
					mem[k] = 16'hFFFF;
	endtask

	// no bypass or fast path: every program needs the full prefix
	task automatic take_write(input logic [19:0] a, input logic [15:0] d);
		int s;
		s = step;
		step = 0;
		if (d == CMD_RESET)
			return;
		case (s)
			0, 4: step = (a == UNLOCK_ADDR1 && d == UNLOCK_DATA1) ? s + 1 : 0;
			1, 5: step = (a == UNLOCK_ADDR2 && d == UNLOCK_DATA2) ? s + 1 : 0;
			2: step = a != UNLOCK_ADDR1 ? 0 : d == CMD_PROGRAM ? 3 : d == CMD_ERASE_SETUP ? 4
				: d == CMD_EXIT_REGION ? 7 : 0;
			3: modify(a, d, 1'b0);
			6:
				if (d == CMD_SECTOR_ERASE)
					modify(a, 16'hFFFF, 1'b1);
			7:
				if (d == CMD_EXIT_TAIL)
					in_region = 1'b0;
			default: ;
		endcase
		if (s == 2 && a == UNLOCK_ADDR1 && d == CMD_ENTER_REGION)
			in_region = 1'b1;
	endtask

	initial
	begin
		o_dq = 16'h0000;
		for (int i = 0; i < 8; i++)
			region[SERIAL_FIRST_WORD + 20'(i)] = SERIAL_SEED + 16'(i);
	end

	always @(negedge i_we_n)
	begin
		t_fall = $time;
		armed = !i_cs_n && i_oe_n && !i_supply_low;
	end

	// glitches and strobes begun in lockout start nothing
	always @(posedge i_we_n)
	begin
		if (armed && !i_cs_n && i_oe_n && !i_supply_low && $time - t_fall >= GLITCH_NS)
			take_write(i_addr, i_dq_out);
		armed = 1'b0;
	end

	always @(posedge i_supply_low or negedge i_init_n)
	begin
		step = 0;
		armed = 1'b0;
		if (!i_init_n)
			in_region = 1'b0;
	end

	// bus is not pulled, so a released bus shows the inverse of the last word
	always @(i_oe_n)
		if (!i_oe_n && !i_cs_n && !i_dq_oe)
			o_dq <= #20 peek(i_addr);
		else
			o_dq <= #5 ~o_dq;
endmodule // flash_device_model

// ---- tb/flash_sector_write_protection_test.sv ----
`timescale 1ns/1ns
module flash_sector_write_protection_test
	import flash_prot_pkg::*;
;
	localparam logic [15:0] SEED = 16'hC000;
	logic clk_sys, rst, hsel, hwrite, supply_low;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout, hresp, dq_oe, cs_n, we_n, oe_n, wp, hv, init_n;
	logic [15:0] dq_in, dq_out;
	logic [19:0] faddr;
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;

	flash_prot_host i_dut
	(
		.i_clk_sys(clk_sys),
		.i_rst(rst),
		.i_hsel(hsel),
		.i_haddr(haddr),
		.i_htrans(htrans),
		.i_hwrite(hwrite),
		.i_hsize(hsize),
		.i_hwdata(hwdata),
		.i_hready(hreadyout),
		.o_hrdata(hrdata),
		.o_hreadyout(hreadyout),
		.o_hresp(hresp),
		.i_dq_in(dq_in),
		.o_flash_addr(faddr),
		.o_dq_out(dq_out),
		.o_dq_oe(dq_oe),
		.o_flash_chip_select_n(cs_n),
		.o_write_strobe_n(we_n),
		.o_output_drive_n(oe_n),
		.o_write_protect_accel_pin(wp),
		.o_high_voltage_level(hv),
		.o_chip_init_n(init_n)
	);

	flash_device_model #(.FACTORY_LOCKED(1'b1), .SERIAL_SEED(SEED)) i_flash
	(
		.i_addr(faddr),
		.i_dq_out(dq_out),
		.i_dq_oe(dq_oe),
		.i_cs_n(cs_n),
		.i_we_n(we_n),
		.i_oe_n(oe_n),
		.i_wp(wp),
		.i_hv(hv),
		.i_init_n(init_n),
		.i_supply_low(supply_low),
		.o_dq(dq_in)
	);

	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic test_done();
		if (n_fail == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge clk_sys)
		if (++cycles == 20000)
		begin
			n_fail++;
			test_done();
		end

	task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", w, exp, seen);
		end
	endtask

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= w;
		do
			@(posedge clk_sys);
		while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do
			@(posedge clk_sys);
		while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic run_op(input logic [2:0] op, input logic [19:0] a, input logic [15:0] d);
		ahb(1'b1, REG_ADDR, {12'h000, a});
		ahb(1'b1, REG_WDATA, {16'h0000, d});
		ahb(1'b1, REG_CTRL, {28'h0000000, op, 1'b1});
		// let busy rise before polling, a stale done would end the wait early
		repeat (2) @(posedge clk_sys);
		rd = 32'h0;
		repeat (100)
			if (rd[1:0] !== 2'b10)
				ahb(1'b0, REG_STATUS, 32'h0);
		check("op done", {30'h0, rd[1:0]}, 32'h2);
	endtask

	task automatic read_chk(input string w, input logic [19:0] a, input logic [15:0] e);
		run_op(OP_READ, a, 16'h0000);
		ahb(1'b0, REG_RDATA, 32'h0);
		check(w, rd, {16'h0000, e});
	endtask

	task automatic prog_chk(input string w, input logic [19:0] a, input logic [15:0] d,
		input logic [15:0] e);
		run_op(OP_PROGRAM, a, d);
		read_chk(w, a, e);
	endtask

	task automatic pins(input logic [2:0] p);
		ahb(1'b1, REG_PINS, {29'h0, p});
	endtask

	task automatic region_chk(input logic e);
		ahb(1'b0, REG_STATUS, 32'h0);
		check("in region", {31'h0, rd[2]}, {31'h0, e});
	endtask

	initial
	begin
		{rst, hsel, hwrite, supply_low} = 4'b1000;
		{haddr, hwdata} = 64'h0;
		htrans = 2'b00;
		hsize = 3'b010;
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		ahb(1'b1, 8'h40, 32'hFFFFFFFF);
		ahb(1'b0, 8'h40, 32'h0);
		check("unmapped read", rd, 32'h0);
		ahb(1'b0, REG_PINS, 32'h0);
		check("pins reset", rd, 32'h00000004);
		check("bus response", {31'h0, hresp}, 32'h0);
		pins(3'b101);
		prog_chk("normal program", 20'h10000, 16'h1234, 16'h1234);
		prog_chk("protected program", 20'h00100, 16'hABCD, 16'hFFFF);
		pins(3'b111);
		prog_chk("temp unprotect", 20'h00100, 16'h5A5A, 16'h5A5A);
		check("hv pin", {31'h0, hv}, 32'h1);
		pins(3'b101);
		prog_chk("protection back", 20'h00101, 16'h1111, 16'hFFFF);
		pins(3'b100);
		prog_chk("boot wp low", 20'hFF010, 16'h2222, 16'hFFFF);
		check("wp pin", {31'h0, wp}, 32'h0);
		pins(3'b101);
		prog_chk("boot wp high", 20'hFF010, 16'h2222, 16'h2222);
		pins(3'b110);
		prog_chk("outer boot hv", 20'hFE020, 16'h3333, 16'hFFFF);
		prog_chk("inner hv", 20'h00102, 16'h4444, 16'h4444);
		pins(3'b101);
		run_op(OP_ENTER_REGION, 20'h00000, 16'h0000);
		region_chk(1'b1);
		read_chk("region map", 20'hFF010, 16'hFFFF);
		for (int i = 0; i < 8; i++)
			read_chk("serial", SERIAL_FIRST_WORD + 20'(i), SEED + 16'(i));
		prog_chk("locked region", 20'hF8003, 16'h0000, SEED + 16'h0003);
		run_op(OP_SECTOR_ERASE, 20'hF8000, 16'h0000);
		read_chk("region erase", 20'hF8000, SEED);
		run_op(OP_EXIT_REGION, 20'h00000, 16'h0000);
		region_chk(1'b0);
		read_chk("boot back", 20'hFF010, 16'h2222);
		run_op(OP_ENTER_REGION, 20'h00000, 16'h0000);
		pins(3'b001);
		repeat (2) @(posedge clk_sys);
		check("init pin", {31'h0, init_n}, 32'h0);
		pins(3'b101);
		region_chk(1'b0);
		read_chk("reset unmaps", 20'hFF010, 16'h2222);
		run_op(OP_SECTOR_ERASE, 20'h10000, 16'h0000);
		read_chk("sector erase", 20'h10000, 16'hFFFF);
		run_op(OP_SECTOR_ERASE, 20'h00100, 16'h0000);
		read_chk("protected erase", 20'h00100, 16'h5A5A);
		run_op(OP_RESET, 20'h00000, 16'h0000);
		run_op(OP_WRITE_RAW, 20'h10011, 16'h6666);
		ahb(1'b0, REG_CTRL, 32'h0);
		check("op readback", rd, {28'h0000000, OP_WRITE_RAW, 1'b0});
		ahb(1'b0, REG_WDATA, 32'h0);
		check("data readback", rd, 32'h00006666);
		ahb(1'b0, REG_ADDR, 32'h0);
		check("address readback", rd, 32'h00010011);
		read_chk("bare write", 20'h10011, 16'hFFFF);
		supply_low <= 1'b1;
		prog_chk("low supply", 20'h10020, 16'h7777, 16'hFFFF);
		supply_low <= 1'b0;
		prog_chk("supply back", 20'h10020, 16'h7777, 16'h7777);
		test_done();
	end
endmodule // flash_sector_write_protection_test
